/* hw/sce_socket_command_engine.sv */
// per-socket command interpreter: decodes host commands, drives socket state
//
// Operation
// [R01] open sets state from protocol: tcp 13, udp 22, ipraw 32, macraw 42, ppp 5f
// [R02] listen, tcp only, moves tcp-ready to awaiting-peer
// [R03] accepted peer connection while listening gives connected and connect flag
// [R04] failed syn/ack delivery while listening sets timeout flag and releases
// [R05] syn to nonexistent port is answered by rst, state unchanged; no rst is sent when another packet request starts in the same cycle
// [R06] connect, tcp only, sends syn to stored destination address and port
// [R07] successful connect gives connected state and connect flag
// [R08] connect fails to released on resolve timeout, stream timeout or rst
// [R09] disconnect, tcp only, sends fin actively or in reply to peer fin
// [R10] after disconnect fin/ack releases; no reply sets timeout then releases
// [R11] rst from peer during communication always releases the socket
// [R12] close releases at once without sending anything
// [R13] send transmits everything between tx read and tx write pointer
// [R14] send with user hardware address, udp only, skips address resolution
// [R15] keep-alive sends one byte probe; no answer or ended link sets timeout
// [R16] receive commit applies host rx read pointer to received-size accounting
// [R17] accepted command is cleared to 00 while it may still run
// [R18] connect flag is set whenever a connection becomes established
// [R19] undefined or invalid command is cleared with no other effect
// [R20] host issues a command only after the previous one cleared
//
// Added by the designer: the placing of the registers and the strobed register port.
module sce_socket_command_engine #(
   parameter int TX_BUF_SIZE = 2048
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // register port
   input wire logic [sce_pkg::ADDR_W-1:0] regAddr,
   input wire logic [sce_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [sce_pkg::DATA_W-1:0] regRdata,
   // packet requests to the packet engine
   output logic pktReq,
   output sce_pkg::sce_pkt_t pktKind,
   output logic [sce_pkg::PTR_W-1:0] pktLen,
   input wire logic [sce_pkg::DEST_IDX_W-1:0] destSel,
   output logic [sce_pkg::DATA_W-1:0] destData,
   // events from the packet engine
   input wire logic peerSyn,
   input wire logic peerAck,
   input wire logic synAckRcvd,
   input wire logic rstRcvd,
   input wire logic finRcvd,
   input wire logic finAckRcvd,
   input wire logic resolveTimeout,
   input wire logic streamTimeout,
   input wire logic noPortSyn,
   input wire logic sendDone,
   input wire logic dataRcvd,
   input wire logic [sce_pkg::PTR_W-1:0] rxWritePtr,
   // status to the rest of the chip
   output sce_pkg::sce_state_t socketState,
   output logic [sce_pkg::DATA_W-1:0] socketEventFlags
);
   import sce_pkg::*;

   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic isDest(input logic [ADDR_W-1:0] a);
      return (a >= OFS_DEST_HW) && (a <= OFS_DEST_LAST);
   endfunction

   function automatic logic [DEST_IDX_W-1:0] destIdx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] d;
      d = a - OFS_DEST_HW;
      return d[DEST_IDX_W-1:0];
   endfunction

   // byte write into a 16-bit value, high byte at the base offset
   function automatic logic [PTR_W-1:0] putByte(input logic [PTR_W-1:0] v,
                                                 input logic lowHalf,
                                                 input logic [DATA_W-1:0] b);
      return lowHalf ? {v[15:8], b} : {b, v[7:0]};
   endfunction

   function automatic logic [DATA_W-1:0] getByte(input logic [PTR_W-1:0] v,
                                                 input logic lowHalf);
      return lowHalf ? v[7:0] : v[15:8];
   endfunction

   function automatic logic hits16(input logic [ADDR_W-1:0] a,
                                   input logic [ADDR_W-1:0] base);
      return a[ADDR_W-1:1] == base[ADDR_W-1:1];
   endfunction

   localparam logic [PTR_W-1:0] TX_SIZE = PTR_W'(TX_BUF_SIZE);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic [DATA_W-1:0] protocol_r, protocol_nxt;
   logic [DATA_W-1:0] cmd_r, cmd_nxt;
   logic [DATA_W-1:0] events_r, events_nxt;
   sce_state_t state_r, state_nxt;
   sce_phase_t phase_r, phase_nxt;
   logic sendBusy_r, sendBusy_nxt;
   logic probeBusy_r, probeBusy_nxt;
   logic [PTR_W-1:0] txWr_r, txWr_nxt;
   logic [PTR_W-1:0] txRd_r, txRd_nxt;
   logic [PTR_W-1:0] txSnap_r, txSnap_nxt;
   logic [PTR_W-1:0] rxRd_r, rxRd_nxt;
   logic [PTR_W-1:0] rxCommit_r, rxCommit_nxt;
   logic [PTR_W-1:0] rxSize_r, rxSize_nxt;
   logic pktReq_r, pktReq_nxt;
   sce_pkt_t pktKind_r, pktKind_nxt;
   logic [PTR_W-1:0] pktLen_r, pktLen_nxt;
   logic [DATA_W-1:0] rdData_r, rdData_nxt;
   logic memSel_r, memSel_nxt;
   logic [DATA_W-1:0] memRdata;
   logic [DATA_W-1:0] setMask;
   logic [DATA_W-1:0] clrMask;
   logic [PROTO_W-1:0] proto;
   logic isTcp;
   logic doClose;
   logic destWr;
   logic [PTR_W-1:0] txUsed;

   assign proto = protocol_r[PROTO_LSB +: PROTO_W];
   assign isTcp = (proto == PROTO_TCP);
   assign txUsed = txWr_r - txRd_r;
   assign destWr = regWr && isDest(regAddr);

   // ------------------------------------------------------------
   // destination address store
   // ------------------------------------------------------------
   sce_dest_mem #(
      .DATA_W(DATA_W),
      .DEPTH(DEST_DEPTH),
      .IDX_W(DEST_IDX_W)
   ) u_dest_mem (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .wrEn(destWr),
      .wrIdx(destIdx(regAddr)),
      .wrData(regWdata),
      .rdIdxA(destIdx(regAddr)),
      .rdDataA(memRdata),
      .rdIdxB(destSel),
      .rdDataB(destData)
   );

   // ------------------------------------------------------------
   // command decode and socket sequencing
   // ------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      phase_nxt = phase_r;
      sendBusy_nxt = sendBusy_r;
      probeBusy_nxt = probeBusy_r;
      txRd_nxt = txRd_r;
      txSnap_nxt = txSnap_r;
      rxCommit_nxt = rxCommit_r;
      cmd_nxt = cmd_r;
      pktKind_nxt = PK_NONE;
      pktLen_nxt = pktLen_r;
      setMask = '0;
      doClose = 1'b0;
      if (cmd_r != CMD_IDLE) begin
         // [R17] clear on accept
         cmd_nxt = CMD_IDLE;
         // [R19] invalid codes fall through
         case (cmd_r)
            CMD_OPEN: begin
               // [R01] state per protocol
               case (proto)
                  PROTO_TCP: state_nxt = ST_TCP_READY;
                  PROTO_UDP: state_nxt = ST_DATAGRAM_OPEN;
                  PROTO_IPRAW: state_nxt = ST_RAW_IP_OPEN;
                  PROTO_MACRAW: state_nxt = ST_RAW_FRAME_OPEN;
                  PROTO_PPPOE: state_nxt = ST_PPP_SESSION_OPEN;
                  default: begin
                  end
               endcase
               if (proto != PROTO_CLOSED && proto <= PROTO_PPPOE) begin
                  phase_nxt = PH_IDLE;
                  sendBusy_nxt = 1'b0;
                  probeBusy_nxt = 1'b0;
               end
            end
            CMD_LISTEN: begin
               // [R02] tcp ready only
               if (isTcp && state_r == ST_TCP_READY) begin
                  state_nxt = ST_AWAITING_PEER;
               end
            end
            CMD_CONNECT: begin
               // [R06] syn to destination
               if (isTcp && state_r == ST_TCP_READY && phase_r == PH_IDLE) begin
                  pktKind_nxt = PK_SYN;
                  phase_nxt = PH_CONNECTING;
               end
            end
            CMD_DISCONNECT: begin
               // [R09] active or passive fin
               if (isTcp && (state_r == ST_CONNECTED || state_r == ST_PEER_CLOSING)) begin
                  pktKind_nxt = PK_FIN;
                  phase_nxt = PH_CLOSING;
               end
            end
            CMD_CLOSE: begin
               // [R12] release, nothing sent
               doClose = 1'b1;
            end
            CMD_SEND: begin
               // [R13] whole tx window
               if (!sendBusy_r && (state_r == ST_CONNECTED || state_r == ST_PEER_CLOSING ||
                   state_r == ST_DATAGRAM_OPEN || state_r == ST_RAW_IP_OPEN ||
                   state_r == ST_RAW_FRAME_OPEN || state_r == ST_PPP_SESSION_OPEN)) begin
                  pktKind_nxt = PK_DATA;
                  pktLen_nxt = txUsed;
                  txSnap_nxt = txWr_r;
                  sendBusy_nxt = 1'b1;
               end
            end
            CMD_SEND_USER_HW: begin
               // [R14] udp, no resolution
               if (!sendBusy_r && proto == PROTO_UDP && state_r == ST_DATAGRAM_OPEN) begin
                  pktKind_nxt = PK_DATA_USER_HW;
                  pktLen_nxt = txUsed;
                  txSnap_nxt = txWr_r;
                  sendBusy_nxt = 1'b1;
               end
            end
            CMD_KEEP_ALIVE: begin
               // [R15] one-byte probe
               if (isTcp && state_r == ST_CONNECTED && !probeBusy_r) begin
                  pktKind_nxt = PK_KEEP;
                  pktLen_nxt = 16'h0001;
                  probeBusy_nxt = 1'b1;
               end else if (isTcp && (state_r == ST_RELEASED || state_r == ST_PEER_CLOSING)) begin
                  setMask[EV_TIMEOUT] = 1'b1;
               end
            end
            CMD_RECEIVE_COMMIT: begin
               // [R16] take host read pointer
               if (state_r != ST_RELEASED) begin
                  rxCommit_nxt = rxRd_r;
               end
            end
            default: begin
            end
         endcase
      end
      if (peerSyn && state_r == ST_AWAITING_PEER && phase_r == PH_IDLE) begin
         pktKind_nxt = PK_SYNACK;
         phase_nxt = PH_ACCEPTING;
      end
      // [R03] accepted while listening
      if (peerAck && phase_r == PH_ACCEPTING) begin
         state_nxt = ST_CONNECTED;
         phase_nxt = PH_IDLE;
         // [R18] connect flag
         setMask[EV_CONNECT] = 1'b1;
      end
      // [R07] client handshake done
      if (synAckRcvd && phase_r == PH_CONNECTING) begin
         state_nxt = ST_CONNECTED;
         phase_nxt = PH_IDLE;
         setMask[EV_CONNECT] = 1'b1;
      end
      if (finRcvd && state_r == ST_CONNECTED && phase_r == PH_IDLE) begin
         state_nxt = ST_PEER_CLOSING;
         setMask[EV_DISCONNECT] = 1'b1;
      end
      // [R10] fin/ack ends the close
      if (finAckRcvd && phase_r == PH_CLOSING) begin
         doClose = 1'b1;
      end
      if (dataRcvd) begin
         setMask[EV_RECEIVE] = 1'b1;
      end
      if (sendDone && sendBusy_r) begin
         sendBusy_nxt = 1'b0;
         txRd_nxt = txSnap_r;
         setMask[EV_SEND_OK] = 1'b1;
      end
      if (peerAck && probeBusy_r) begin
         probeBusy_nxt = 1'b0;
      end
      // [R04] [R08] [R10] [R15] stream timeout releases
      if (streamTimeout && (phase_r != PH_IDLE || probeBusy_r ||
          state_r == ST_AWAITING_PEER)) begin
         setMask[EV_TIMEOUT] = 1'b1;
         doClose = 1'b1;
      end
      // [R08] resolve timeout
      if (resolveTimeout && (phase_r == PH_CONNECTING || sendBusy_r)) begin
         setMask[EV_TIMEOUT] = 1'b1;
         sendBusy_nxt = 1'b0;
         if (phase_r == PH_CONNECTING) begin
            doClose = 1'b1;
         end
      end
      // [R11] [R08] peer reset releases
      if (rstRcvd && isTcp && state_r != ST_RELEASED) begin
         doClose = 1'b1;
      end
      if (doClose) begin
         state_nxt = ST_RELEASED;
         phase_nxt = PH_IDLE;
         sendBusy_nxt = 1'b0;
         probeBusy_nxt = 1'b0;
      end
      // [R05] rst for unknown port; a packet started this cycle keeps the slot
      if (noPortSyn && pktKind_nxt == PK_NONE) begin
         pktKind_nxt = PK_RST;
         pktLen_nxt = '0;
      end
      // new host command wins over the clear of the old one
      if (regWr && regAddr == OFS_COMMAND) begin
         cmd_nxt = regWdata;
      end
      clrMask = (regWr && regAddr == OFS_EVENTS) ? regWdata : '0;
      // set wins over write-one-to-clear
      events_nxt = (events_r & ~clrMask) | setMask;
      pktReq_nxt = (pktKind_nxt != PK_NONE);
      rxSize_nxt = rxWritePtr - rxCommit_nxt;
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         cmd_r <= RST_COMMAND;
         events_r <= RST_EVENTS;
         state_r <= ST_RELEASED;
         phase_r <= PH_IDLE;
         sendBusy_r <= 1'b0;
         probeBusy_r <= 1'b0;
         txRd_r <= RST_PTR;
         txSnap_r <= RST_PTR;
         rxCommit_r <= RST_PTR;
         rxSize_r <= RST_PTR;
         pktReq_r <= 1'b0;
         pktKind_r <= PK_NONE;
         pktLen_r <= RST_PTR;
      end else begin
         cmd_r <= cmd_nxt;
         events_r <= events_nxt;
         state_r <= state_nxt;
         phase_r <= phase_nxt;
         sendBusy_r <= sendBusy_nxt;
         probeBusy_r <= probeBusy_nxt;
         txRd_r <= txRd_nxt;
         txSnap_r <= txSnap_nxt;
         rxCommit_r <= rxCommit_nxt;
         rxSize_r <= rxSize_nxt;
         pktReq_r <= pktReq_nxt;
         pktKind_r <= pktKind_nxt;
         pktLen_r <= pktLen_nxt;
      end
   end

   // ------------------------------------------------------------
   // host-written settings and read path
   // ------------------------------------------------------------
   always_comb begin
      protocol_nxt = protocol_r;
      txWr_nxt = txWr_r;
      rxRd_nxt = rxRd_r;
      if (regWr && regAddr == OFS_PROTOCOL) begin
         protocol_nxt = regWdata;
      end
      if (regWr && hits16(regAddr, OFS_TX_WR)) begin
         txWr_nxt = putByte(txWr_r, regAddr[0], regWdata);
      end
      if (regWr && hits16(regAddr, OFS_RX_RD)) begin
         rxRd_nxt = putByte(rxRd_r, regAddr[0], regWdata);
      end
      // unmapped and idle cycles read as zero
      rdData_nxt = '0;
      memSel_nxt = regRd && isDest(regAddr);
      if (regRd) begin
         if (regAddr == OFS_PROTOCOL) begin
            rdData_nxt = protocol_r;
         end else if (regAddr == OFS_COMMAND) begin
            rdData_nxt = cmd_r;
         end else if (regAddr == OFS_EVENTS) begin
            rdData_nxt = events_r;
         end else if (regAddr == OFS_STATE) begin
            rdData_nxt = state_r;
         end else if (hits16(regAddr, OFS_TX_FREE)) begin
            rdData_nxt = getByte(TX_SIZE - txUsed, regAddr[0]);
         end else if (hits16(regAddr, OFS_TX_RD)) begin
            rdData_nxt = getByte(txRd_r, regAddr[0]);
         end else if (hits16(regAddr, OFS_TX_WR)) begin
            rdData_nxt = getByte(txWr_r, regAddr[0]);
         end else if (hits16(regAddr, OFS_RX_SIZE)) begin
            rdData_nxt = getByte(rxSize_r, regAddr[0]);
         end else if (hits16(regAddr, OFS_RX_RD)) begin
            rdData_nxt = getByte(rxRd_r, regAddr[0]);
         end else if (hits16(regAddr, OFS_RX_WR)) begin
            rdData_nxt = getByte(rxWritePtr, regAddr[0]);
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         protocol_r <= RST_PROTOCOL;
         txWr_r <= RST_PTR;
         rxRd_r <= RST_PTR;
         rdData_r <= '0;
         memSel_r <= 1'b0;
      end else begin
         protocol_r <= protocol_nxt;
         txWr_r <= txWr_nxt;
         rxRd_r <= rxRd_nxt;
         rdData_r <= rdData_nxt;
         memSel_r <= memSel_nxt;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign regRdata = memSel_r ? memRdata : rdData_r;
   assign pktReq = pktReq_r;
   assign pktKind = pktKind_r;
   assign pktLen = pktLen_r;
   assign socketState = state_r;
   assign socketEventFlags = events_r;

endmodule

/* hw/sce_pkg.sv */
// constants, encodings and types shared by the socket command engine
package sce_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int PTR_W = 16;
   localparam int DEST_IDX_W = 4;
   localparam int DEST_DEPTH = 12;

   // ------------------------------------------------------------
   // register offsets (16-bit values: high byte at the lower offset)
   // ------------------------------------------------------------
   localparam logic [5:0] OFS_PROTOCOL = 6'h00;
   localparam logic [5:0] OFS_COMMAND = 6'h01;
   localparam logic [5:0] OFS_EVENTS = 6'h02;
   localparam logic [5:0] OFS_STATE = 6'h03;
   localparam logic [5:0] OFS_DEST_HW = 6'h06;
   localparam logic [5:0] OFS_DEST_IP = 6'h0c;
   localparam logic [5:0] OFS_DEST_PORT = 6'h10;
   localparam logic [5:0] OFS_DEST_LAST = 6'h11;
   localparam logic [5:0] OFS_TX_FREE = 6'h20;
   localparam logic [5:0] OFS_TX_RD = 6'h22;
   localparam logic [5:0] OFS_TX_WR = 6'h24;
   localparam logic [5:0] OFS_RX_SIZE = 6'h26;
   localparam logic [5:0] OFS_RX_RD = 6'h28;
   localparam logic [5:0] OFS_RX_WR = 6'h2a;

   // ------------------------------------------------------------
   // fields and reset values
   // ------------------------------------------------------------
   localparam int PROTO_LSB = 0;
   localparam int PROTO_W = 4;
   localparam logic [7:0] RST_PROTOCOL = 8'h00;
   localparam logic [7:0] RST_COMMAND = 8'h00;
   localparam logic [7:0] RST_EVENTS = 8'h00;
   localparam logic [15:0] RST_PTR = 16'h0000;
   localparam int EV_CONNECT = 0;
   localparam int EV_DISCONNECT = 1;
   localparam int EV_RECEIVE = 2;
   localparam int EV_TIMEOUT = 3;
   localparam int EV_SEND_OK = 4;

   // ------------------------------------------------------------
   // protocol and command codes
   // ------------------------------------------------------------
   localparam logic [3:0] PROTO_CLOSED = 4'h0;
   localparam logic [3:0] PROTO_TCP = 4'h1;
   localparam logic [3:0] PROTO_UDP = 4'h2;
   localparam logic [3:0] PROTO_IPRAW = 4'h3;
   localparam logic [3:0] PROTO_MACRAW = 4'h4;
   localparam logic [3:0] PROTO_PPPOE = 4'h5;
   localparam logic [7:0] CMD_IDLE = 8'h00;
   localparam logic [7:0] CMD_OPEN = 8'h01;
   localparam logic [7:0] CMD_LISTEN = 8'h02;
   localparam logic [7:0] CMD_CONNECT = 8'h04;
   localparam logic [7:0] CMD_DISCONNECT = 8'h08;
   localparam logic [7:0] CMD_CLOSE = 8'h10;
   localparam logic [7:0] CMD_SEND = 8'h20;
   localparam logic [7:0] CMD_SEND_USER_HW = 8'h21;
   localparam logic [7:0] CMD_KEEP_ALIVE = 8'h22;
   localparam logic [7:0] CMD_RECEIVE_COMMIT = 8'h40;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [7:0] {
      ST_RELEASED = 8'h00,
      ST_TCP_READY = 8'h13,
      ST_AWAITING_PEER = 8'h14,
      ST_CONNECTED = 8'h17,
      ST_PEER_CLOSING = 8'h1c,
      ST_DATAGRAM_OPEN = 8'h22,
      ST_RAW_IP_OPEN = 8'h32,
      ST_RAW_FRAME_OPEN = 8'h42,
      ST_PPP_SESSION_OPEN = 8'h5f
   } sce_state_t;

   typedef enum logic [1:0] {
      PH_IDLE = 2'h0,
      PH_CONNECTING = 2'h1,
      PH_ACCEPTING = 2'h3,
      PH_CLOSING = 2'h2
   } sce_phase_t;

   typedef enum logic [2:0] {
      PK_NONE = 3'h0,
      PK_SYN = 3'h1,
      PK_SYNACK = 3'h2,
      PK_FIN = 3'h3,
      PK_RST = 3'h4,
      PK_KEEP = 3'h5,
      PK_DATA = 3'h6,
      PK_DATA_USER_HW = 3'h7
   } sce_pkt_t;

endpackage

/* hw/sce_dest_mem.sv */
// small destination address store with two registered read ports
module sce_dest_mem #(
   parameter int DATA_W = 8,
   parameter int DEPTH = 12,
   parameter int IDX_W = 4
) (
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // write port
   input wire logic wrEn,
   input wire logic [IDX_W-1:0] wrIdx,
   input wire logic [DATA_W-1:0] wrData,
   // host read port
   input wire logic [IDX_W-1:0] rdIdxA,
   output logic [DATA_W-1:0] rdDataA,
   // engine read port
   input wire logic [IDX_W-1:0] rdIdxB,
   output logic [DATA_W-1:0] rdDataB
);

   logic [DATA_W-1:0] mem [DEPTH];

   // out-of-range indices read as zero
   always_ff @(posedge clk_sys) begin
      if (wrEn && (int'(wrIdx) < DEPTH)) begin
         mem[wrIdx] <= wrData;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         rdDataA <= '0;
         rdDataB <= '0;
      end else begin
         rdDataA <= (int'(rdIdxA) < DEPTH) ? mem[rdIdxA] : '0;
         rdDataB <= (int'(rdIdxB) < DEPTH) ? mem[rdIdxB] : '0;
      end
   end

endmodule

/* verification/sce_socket_command_engine_asserts.sv */
// port checker for the socket command engine
module sce_socket_command_engine_asserts
   import sce_pkg::*;
#(
   parameter int TX_BUF_SIZE = 2048
) (
   // clock, reset, register port
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic [sce_pkg::ADDR_W-1:0] regAddr,
   input wire logic [sce_pkg::DATA_W-1:0] regWdata,
   input wire logic regWr,
   // packet side
   input wire logic pktReq,
   input wire sce_pkg::sce_pkt_t pktKind,
   input wire logic [sce_pkg::PTR_W-1:0] pktLen,
   input wire logic rstRcvd,
   input wire logic streamTimeout,
   input wire logic noPortSyn,
   // status
   input wire sce_pkg::sce_state_t socketState,
   input wire logic [sce_pkg::DATA_W-1:0] socketEventFlags
);
   logic [3:0] proto_r;
   wire cmdWr = regWr && regAddr == OFS_COMMAND;
   // protocol shadow: open result depends on it
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) proto_r <= 4'h0;
      else if (regWr && regAddr == OFS_PROTOCOL) proto_r <= regWdata[3:0];
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   chk_open_tcp_ready: assert property (
      cmdWr && regWdata == CMD_OPEN && proto_r == PROTO_TCP |-> ##2 socketState == ST_TCP_READY)
      else $error("open tcp");
   chk_listen_awaits: assert property (
      cmdWr && regWdata == CMD_LISTEN && proto_r == PROTO_TCP && socketState == ST_TCP_READY
      |-> ##2 socketState == ST_AWAITING_PEER) else $error("listen");
   chk_connect_syn: assert property (
      cmdWr && regWdata == CMD_CONNECT && proto_r == PROTO_TCP && socketState == ST_TCP_READY
      |-> ##2 pktReq && pktKind == PK_SYN) else $error("no syn");
   chk_close_quiet: assert property (
      cmdWr && regWdata == CMD_CLOSE |-> ##2 socketState == ST_RELEASED && !pktReq)
      else $error("close");
   chk_noport_rst: assert property (
      noPortSyn |=> pktReq && pktKind == PK_RST && $stable(socketState))
      else $error("no rst");
   chk_rst_releases: assert property (
      rstRcvd && socketState[7:4] == 4'h1
      |=> socketState == ST_RELEASED) else $error("peer rst");
   chk_listen_timeout: assert property (
      streamTimeout && socketState == ST_AWAITING_PEER
      |=> socketState == ST_RELEASED && socketEventFlags[EV_TIMEOUT]) else $error("timeout");
   chk_connect_flag: assert property (
      $rose(socketState == ST_CONNECTED) |-> socketEventFlags[EV_CONNECT])
      else $error("no connect flag");
   chk_keep_one_byte: assert property (
      pktReq && pktKind == PK_KEEP |-> pktLen == 16'h0001) else $error("keep len");
   cover property (socketState == ST_CONNECTED);
   cover property (pktReq && pktKind == PK_DATA);
   cover property (socketEventFlags[EV_TIMEOUT]);
endmodule
bind sce_socket_command_engine sce_socket_command_engine_asserts #(.TX_BUF_SIZE(TX_BUF_SIZE))
   u_sce_socket_command_engine_asserts (.clk_sys, .nrst, .regAddr, .regWdata, .regWr, .pktReq,
   .pktKind, .pktLen, .rstRcvd, .streamTimeout, .noPortSyn, .socketState, .socketEventFlags);

/* verification/sce_socket_command_engine_test.sv */
// self-checking bench for the socket command engine
module sce_socket_command_engine_test;
   timeunit 1ns;
   timeprecision 1ps;
   import sce_pkg::*;
   logic clk_sys = 1'b0;
   logic nrst, regWr, regRd, pktReq;
   logic [5:0] regAddr;
   logic [7:0] regWdata, regRdata, destData, socketEventFlags;
   logic [3:0] destSel;
   logic [15:0] pktLen, rxWritePtr;
   logic [10:0] ev;
   sce_pkt_t pktKind;
   sce_state_t socketState;
   int error_cnt = 0, tests_run = 0;
   logic [7:0] openSt [6] = '{8'h00, 8'h13, 8'h22, 8'h32, 8'h42, 8'h5f};
   int failEv [3] = '{6, 7, 3};
   always #10 clk_sys = ~clk_sys;
   // event bits: syn ack synack rst fin finack resolve stream noport senddone data
   sce_socket_command_engine u_sce_socket_command_engine (.clk_sys, .nrst, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .pktReq, .pktKind, .pktLen, .destSel, .destData,
      .peerSyn(ev[0]), .peerAck(ev[1]), .synAckRcvd(ev[2]), .rstRcvd(ev[3]), .finRcvd(ev[4]),
      .finAckRcvd(ev[5]), .resolveTimeout(ev[6]), .streamTimeout(ev[7]), .noPortSyn(ev[8]),
      .sendDone(ev[9]), .dataRcvd(ev[10]), .rxWritePtr, .socketState, .socketEventFlags);
   task automatic test_done();
      if (error_cnt == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      regAddr <= a; regWdata <= d; regWr <= 1'b1;
      @(posedge clk_sys);
      regWr <= 1'b0;
   endtask
   task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
      @(posedge clk_sys);
      regAddr <= a; regRd <= 1'b1;
      @(posedge clk_sys);
      regRd <= 1'b0;
      #1 chk(regRdata, exp);
   endtask
   // one command at a time, result one edge after the write
   task automatic cmd(input logic [7:0] c, input logic [2:0] pk);
      wr(OFS_COMMAND, c);
      @(posedge clk_sys);
      #1 chk(pktReq ? {1'b1, pktKind} : 4'h0, {pk != 3'h0, pk});
   endtask
   task automatic evp(input int i, input logic [2:0] pk);
      @(posedge clk_sys);
      ev[i] <= 1'b1;
      @(posedge clk_sys);
      ev <= '0;
      #1 chk(pktReq ? {1'b1, pktKind} : 4'h0, {pk != 3'h0, pk});
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys);
      error_cnt++;
      test_done();
   end
   initial begin
      nrst = 1'b0; regWr = 1'b0; regRd = 1'b0; regAddr = 6'h00; regWdata = 8'h00;
      destSel = 4'h0; ev = '0; rxWritePtr = 16'h0000;
      repeat (5) @(posedge clk_sys);
      nrst <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wr(OFS_PROTOCOL, 8'(i));
         cmd(CMD_OPEN, PK_NONE);
         chk(socketState, openSt[i]);
      end
      rdc(OFS_COMMAND, 8'h00);
      cmd(8'h77, PK_NONE);
      cmd(CMD_LISTEN, PK_NONE);
      rdc(OFS_STATE, 8'h5f);
      cmd(CMD_CLOSE, PK_NONE);
      chk(socketState, ST_RELEASED);
      wr(OFS_PROTOCOL, 8'h01);
      cmd(CMD_OPEN, PK_NONE);
      cmd(CMD_LISTEN, PK_NONE);
      evp(8, PK_RST);
      chk(socketState, ST_AWAITING_PEER);
      evp(0, PK_SYNACK);
      evp(1, PK_NONE);
      rdc(OFS_EVENTS, 8'h01);
      wr(OFS_EVENTS, 8'hff);
      cmd(CMD_DISCONNECT, PK_FIN);
      chk(socketState, ST_CONNECTED);
      evp(5, PK_NONE);
      chk(socketState, ST_RELEASED);
      cmd(CMD_OPEN, PK_NONE);
      cmd(CMD_LISTEN, PK_NONE);
      evp(7, PK_NONE);
      chk({socketState, socketEventFlags}, 16'h0008);
      wr(OFS_DEST_IP, 8'hc0);
      wr(OFS_DEST_LAST, 8'h50);
      for (int k = 0; k < 2; k++) begin
         @(posedge clk_sys);
         destSel <= k ? 4'hb : 4'h6;
         @(posedge clk_sys);
         #1 chk(destData, k ? 8'h50 : 8'hc0);
      end
      cmd(CMD_OPEN, PK_NONE);
      cmd(CMD_CONNECT, PK_SYN);
      evp(2, PK_NONE);
      chk({socketState, 7'h00, socketEventFlags[EV_CONNECT]}, 16'h1701);
      cmd(CMD_KEEP_ALIVE, PK_KEEP);
      chk(pktLen, 16'h0001);
      wr(6'h25, 8'h10);
      cmd(CMD_SEND, PK_DATA);
      chk(pktLen, 16'h0010);
      evp(9, PK_NONE);
      chk(socketEventFlags[EV_SEND_OK], 1'b1);
      evp(3, PK_NONE);
      chk(socketState, ST_RELEASED);
      for (int k = 0; k < 3; k++) begin
         cmd(CMD_OPEN, PK_NONE);
         cmd(CMD_CONNECT, PK_SYN);
         evp(failEv[k], PK_NONE);
         chk(socketState, ST_RELEASED);
      end
      wr(OFS_PROTOCOL, 8'h02);
      cmd(CMD_OPEN, PK_NONE);
      cmd(CMD_SEND_USER_HW, PK_DATA_USER_HW);
      rxWritePtr <= 16'h0030;
      wr(6'h29, 8'h10);
      rdc(6'h27, 8'h30);
      cmd(CMD_RECEIVE_COMMIT, PK_NONE);
      rdc(6'h27, 8'h20);
      test_done();
   end
endmodule
